//--- hdl/cdrst_defines.svh
`ifndef CDRST_DEFINES_SVH
`define CDRST_DEFINES_SVH

// register byte offsets
`define CDRST_OFS_ENABLE 12'h000
`define CDRST_OFS_SELECT 12'h004
`define CDRST_OFS_OPTION 12'h008
`define CDRST_OFS_EPR 12'h00C
`define CDRST_OFS_TARGET 12'h010
`define CDRST_OFS_COUNT 12'h014
`define CDRST_OFS_STATUS 12'h018

// selector value of this function
`define CDRST_SEL_CODE 32'h0000000C

// option field positions
`define CDRST_OPT_EDGE 0
`define CDRST_OPT_RSVD 1
`define CDRST_OPT_ONCE 2

// status field positions
`define CDRST_ST_FLAG 0
`define CDRST_ST_BUSY 1
`define CDRST_ST_FIRED 2
`define CDRST_ST_DROP_LSB 8
`define CDRST_ST_LOST_LSB 16

// reset values
`define CDRST_RST_WORD 32'h00000000
`define CDRST_RST_CNT8 8'h00

// service time: 14 us, longest time so rounded down
`define CDRST_SVC_NS 14000
`define CDRST_CLK_NS 10
`define CDRST_SVC_CYC (`CDRST_SVC_NS / `CDRST_CLK_NS)

`endif

//--- hdl/cdrst_pkg.sv
package cdrst_pkg;
    typedef logic [31:0] cdrst_word_t;
    typedef logic [11:0] cdrst_addr_t;
    typedef logic [10:0] cdrst_tmr_t;
    typedef enum logic {CDRST_IDLE, CDRST_RUN} cdrst_svc_e;
endpackage

//--- hdl/cdrst_svc.sv
`timescale 1ns/10ps
`include "cdrst_defines.svh"
module cdrst_svc (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic edge_p,
    input wire logic edge_rise,
    input wire logic other_busy,
    input wire logic stream_hold,
    output logic flag_q,
    output logic busy_q,
    output logic done_q,
    output logic done_rise_q,
    output logic drop_q,
    output logic lost_q
);
    import cdrst_pkg::*;

    localparam cdrst_tmr_t SVC_LAST = cdrst_tmr_t'(`CDRST_SVC_CYC - 1);

    cdrst_svc_e st_q;
    cdrst_tmr_t tmr_q;
    logic pend_rise_q;
    logic fin;

    assign fin = (st_q == CDRST_RUN) && !stream_hold && (tmr_q == '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= CDRST_IDLE;
            tmr_q <= '0;
            done_q <= 1'b0;
            done_rise_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                CDRST_IDLE: begin
                    if (flag_q && !other_busy && !stream_hold) begin
                        st_q <= CDRST_RUN;
                        tmr_q <= SVC_LAST;
                        done_rise_q <= pend_rise_q;
                    end
                end
                CDRST_RUN: begin
                    if (fin) begin
                        st_q <= CDRST_IDLE;
                        done_q <= 1'b1;
                    end else if (!stream_hold) begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
            endcase
        end
    end

    assign busy_q = (st_q == CDRST_RUN);

    // flag set by edge, cleared by completion; set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
            pend_rise_q <= 1'b0;
            drop_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            drop_q <= 1'b0;
            lost_q <= 1'b0;
            if (edge_p && (!busy_q || fin)) begin
                lost_q <= flag_q && !busy_q;
                flag_q <= 1'b1;
                pend_rise_q <= edge_rise;
            end else if (edge_p) begin
                drop_q <= 1'b1;
            end else if (fin) begin
                flag_q <= 1'b0;
            end
        end
    end
endmodule // cdrst_svc

//--- hdl/cdrst_sync.sv
`timescale 1ns/10ps
module cdrst_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic edge_p,
    output logic edge_rise
);
    logic s1_q, s2_q, s3_q, lvl_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            lvl_q <= s3_q;
        end
    end

    assign edge_p = (s2_q == s3_q) && (s3_q != lvl_q);
    assign edge_rise = s3_q;
endmodule // cdrst_sync

//--- hdl/cdrst_top.sv
`timescale 1ns/10ps
`include "cdrst_defines.svh"
// Functional notes
// - count edges, reset target after programmed count
// - selector value twelve selects this function
// - option bit zero picks edge polarity
// - option bit two: single reset only
// - edges_per_reset sets edges per reset
// - target_line_number names the reset target
// - current_edge_count reads present count
// - no updates while running
// - reset event zeroes target's count; with option bit two set the count keeps incrementing instead
// - edges of both polarities serviced unless dropped or lost
// - edge sets flag, completion clears it
// - service routine not preempted by edges
// - service takes at most 14 us, not counting stream stalls
// - edge during own service dropped
// - new edge loses earlier pending edge
module cdrst_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire cdrst_pkg::cdrst_addr_t paddr,
    input wire cdrst_pkg::cdrst_word_t pwdata,
    output cdrst_pkg::cdrst_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_in,
    input wire logic other_isr_busy,
    input wire logic stream_isr_busy,
    output logic line_isr_busy,
    output logic line_irq_flag,
    output logic tgt_clear,
    output cdrst_pkg::cdrst_word_t tgt_line
);
    import cdrst_pkg::*;

    logic rst_a_q, rst_n;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    function automatic logic hit(input cdrst_addr_t a, input cdrst_addr_t ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    cdrst_word_t en_q, sel_q, opt_q, epr_q, tgt_q, cnt_q;
    logic fired_q, active_q;
    logic [7:0] drop_cnt_q, lost_cnt_q;
    logic active, wr_acc, acc, mapped, cfg_hit, bad;
    logic edge_p, edge_rise, svc_edge;
    logic flag, busy, done, done_rise, drop, lost;
    logic qual, reach;
    cdrst_word_t cnt_inc, rd_d, status;

    assign active = en_q[0] && (sel_q == `CDRST_SEL_CODE);

    cdrst_sync u_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .pin(line_in),
        .edge_p(edge_p),
        .edge_rise(edge_rise)
    );

    assign svc_edge = edge_p && active;

    cdrst_svc u_svc (
        .clk(ref_clk),
        .rst_n(rst_n),
        .edge_p(svc_edge),
        .edge_rise(edge_rise),
        .other_busy(other_isr_busy),
        .stream_hold(stream_isr_busy),
        .flag_q(flag),
        .busy_q(busy),
        .done_q(done),
        .done_rise_q(done_rise),
        .drop_q(drop),
        .lost_q(lost)
    );

    // apb decode
    assign acc = psel && penable;
    assign wr_acc = acc && pwrite && pready;
    assign cfg_hit = hit(paddr, `CDRST_OFS_SELECT) || hit(paddr, `CDRST_OFS_OPTION)
        || hit(paddr, `CDRST_OFS_EPR) || hit(paddr, `CDRST_OFS_TARGET);
    assign mapped = cfg_hit || hit(paddr, `CDRST_OFS_ENABLE)
        || hit(paddr, `CDRST_OFS_COUNT) || hit(paddr, `CDRST_OFS_STATUS);
    // config locked while running; count and status read only
    assign bad = !mapped || (pwrite && ((cfg_hit && active)
        || hit(paddr, `CDRST_OFS_COUNT) || hit(paddr, `CDRST_OFS_STATUS)));

    // one wait state keeps pready and prdata registered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `CDRST_RST_WORD;
        end else begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && bad;
            if (acc && !pready && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    assign status = {8'h00, lost_cnt_q, drop_cnt_q, 5'h00, fired_q, busy, flag};

    always_comb begin
        rd_d = `CDRST_RST_WORD;
        if (hit(paddr, `CDRST_OFS_ENABLE)) begin
            rd_d = en_q;
        end else if (hit(paddr, `CDRST_OFS_SELECT)) begin
            rd_d = sel_q;
        end else if (hit(paddr, `CDRST_OFS_OPTION)) begin
            rd_d = opt_q;
        end else if (hit(paddr, `CDRST_OFS_EPR)) begin
            rd_d = epr_q;
        end else if (hit(paddr, `CDRST_OFS_TARGET)) begin
            rd_d = tgt_q;
        end else if (hit(paddr, `CDRST_OFS_COUNT)) begin
            rd_d = cnt_q;
        end else if (hit(paddr, `CDRST_OFS_STATUS)) begin
            rd_d = status;
        end
    end

    // software registers; bit 0 of enable only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= `CDRST_RST_WORD;
            sel_q <= `CDRST_RST_WORD;
            opt_q <= `CDRST_RST_WORD;
            epr_q <= `CDRST_RST_WORD;
            tgt_q <= `CDRST_RST_WORD;
        end else if (wr_acc && !bad) begin
            if (hit(paddr, `CDRST_OFS_ENABLE)) begin
                en_q <= {31'h0, pwdata[0]};
            end
            if (hit(paddr, `CDRST_OFS_SELECT)) begin
                sel_q <= pwdata;
            end
            // reserved bits stored as written, unused by logic
            if (hit(paddr, `CDRST_OFS_OPTION)) begin
                opt_q <= pwdata;
            end
            if (hit(paddr, `CDRST_OFS_EPR)) begin
                epr_q <= pwdata;
            end
            if (hit(paddr, `CDRST_OFS_TARGET)) begin
                tgt_q <= pwdata;
            end
        end
    end

    assign qual = done && (done_rise == opt_q[`CDRST_OPT_EDGE]) && active;
    assign cnt_inc = cnt_q + 32'h00000001;
    // zero programmed edges acts as one
    assign reach = (cnt_inc >= epr_q) || (epr_q == `CDRST_RST_WORD);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            cnt_q <= `CDRST_RST_WORD;
            fired_q <= 1'b0;
        end else begin
            active_q <= active;
            if (active && !active_q) begin
                cnt_q <= `CDRST_RST_WORD;
                fired_q <= 1'b0;
            end else if (qual) begin
                if (reach && !opt_q[`CDRST_OPT_ONCE]) begin
                    cnt_q <= `CDRST_RST_WORD;
                end else begin
                    cnt_q <= cnt_inc;
                end
                if (reach) begin
                    fired_q <= 1'b1;
                end
            end
        end
    end

    // single mode fires once; pulse clears target
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgt_clear <= 1'b0;
            tgt_line <= `CDRST_RST_WORD;
        end else begin
            tgt_clear <= qual && reach && !(opt_q[`CDRST_OPT_ONCE] && fired_q);
            if (qual && reach) begin
                tgt_line <= tgt_q;
            end
        end
    end

    // diagnostic tallies, restarted on enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_cnt_q <= `CDRST_RST_CNT8;
            lost_cnt_q <= `CDRST_RST_CNT8;
        end else if (active && !active_q) begin
            drop_cnt_q <= `CDRST_RST_CNT8;
            lost_cnt_q <= `CDRST_RST_CNT8;
        end else begin
            if (drop) begin
                drop_cnt_q <= sat_inc(drop_cnt_q);
            end
            if (lost) begin
                lost_cnt_q <= sat_inc(lost_cnt_q);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_isr_busy <= 1'b0;
            line_irq_flag <= 1'b0;
        end else begin
            line_isr_busy <= busy;
            line_irq_flag <= flag;
        end
    end

    localparam int SVC_C = `CDRST_SVC_CYC;

    cdrst_tmr_t svc_run_q;

    // service outlasts any delay window, so count its unstalled cycles;
    // the count stops at all ones rather than wrapping back under the limit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            svc_run_q <= '0;
        end else if (!busy) begin
            svc_run_q <= '0;
        end else if (!stream_isr_busy && svc_run_q != '1) begin
            svc_run_q <= svc_run_q + 1'b1;
        end
    end

    a_fire_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done && active && done_rise == opt_q[`CDRST_OPT_EDGE] && !fired_q
        && cnt_q + 32'h00000001 == epr_q |=> tgt_clear)
        else $error("reset event missing");

    a_sel_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tgt_clear |-> $past(sel_q) == `CDRST_SEL_CODE)
        else $error("fired with wrong selector");

    a_edge_pol: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done && active && done_rise != opt_q[`CDRST_OPT_EDGE] && !(active && !active_q)
        |=> cnt_q == $past(cnt_q))
        else $error("wrong polarity counted");

    a_once_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        opt_q[`CDRST_OPT_ONCE] && fired_q && active_q && $stable(opt_q) |=> !tgt_clear)
        else $error("second reset in single mode");

    a_target_line: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tgt_clear |-> tgt_line == $past(tgt_q))
        else $error("wrong target line");

    a_cfg_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        acc && pready && pwrite && active && cfg_hit
        |-> pslverr ##1 $stable(sel_q) && $stable(opt_q) && $stable(epr_q) && $stable(tgt_q))
        else $error("config changed while running");

    a_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        svc_edge && !busy |=> flag)
        else $error("flag not set by edge");

    a_svc_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(busy) && !stream_isr_busy ##1 !stream_isr_busy [*8] |-> busy)
        else $error("service ended early");

    a_svc_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy |-> svc_run_q < SVC_C)
        else $error("service overran");

    a_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        qual && reach && !opt_q[`CDRST_OPT_ONCE] && active_q |=> cnt_q == `CDRST_RST_WORD)
        else $error("count not restarted");

    a_edge_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        svc_edge && busy |=> drop || !busy)
        else $error("edge in service not dropped");

    a_edge_lost: assert property (@(posedge ref_clk) disable iff (!rst_n)
        svc_edge && flag && !busy |=> lost && flag)
        else $error("pending edge not replaced");

    a_read_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        acc && pready && !pwrite && hit(paddr, `CDRST_OFS_COUNT) |-> prdata == $past(cnt_q))
        else $error("count read mismatch");

    a_clear_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tgt_clear |=> !tgt_clear)
        else $error("target clear longer than one cycle");

    a_start_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !busy && (other_isr_busy || stream_isr_busy) |=> !busy)
        else $error("service started while blocked");

    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done && !$past(svc_edge) |-> !flag)
        else $error("flag not cleared by completion");

    a_busy_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy |-> flag)
        else $error("flag dropped during service");

    c_fire: cover property (@(posedge ref_clk) disable iff (!rst_n) tgt_clear);
    c_drop: cover property (@(posedge ref_clk) disable iff (!rst_n) drop);
    c_lost: cover property (@(posedge ref_clk) disable iff (!rst_n) lost);
    c_stall: cover property (@(posedge ref_clk) disable iff (!rst_n) busy && stream_isr_busy);
    c_read_cnt: cover property (@(posedge ref_clk) disable iff (!rst_n)
        acc && pready && !pwrite && hit(paddr, `CDRST_OFS_COUNT) && prdata != 0);
endmodule // cdrst_top

//--- testbench/cdrst_src.sv
`timescale 1ns/10ps
module cdrst_src (
    input wire logic clk,
    output logic line
);
    // a level line with a driver, so it simply holds between edges
    initial line = 1'b0;

    task automatic drive(input logic v, input int gap);
        @(posedge clk);
        line <= v;
        repeat (gap) @(posedge clk);
    endtask
endmodule // cdrst_src

//--- testbench/test_cdrst_top.sv
`timescale 1ns/10ps
`include "cdrst_defines.svh"
module test_cdrst_top;
    import cdrst_pkg::*;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, erv, flag_d;
    logic other_isr_busy, stream_isr_busy, line_isr_busy, line_irq_flag, tgt_clear, line_in;
    cdrst_addr_t paddr;
    cdrst_word_t pwdata, prdata, tgt_line, rdv;
    int n_fail, check_count, n_clr, n_flag;

    cdrst_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .other_isr_busy(other_isr_busy),
        .stream_isr_busy(stream_isr_busy), .line_isr_busy(line_isr_busy),
        .line_irq_flag(line_irq_flag), .tgt_clear(tgt_clear), .tgt_line(tgt_line));
    cdrst_src u_src (.clk(ref_clk), .line(line_in));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // pulses are one cycle wide, so count them as they pass
    always @(posedge ref_clk) begin
        if (tgt_clear === 1'b1) n_clr++;
        if (line_irq_flag === 1'b1 && flag_d !== 1'b1) n_flag++;
        flag_d <= line_irq_flag;
    end

    task automatic chk(input string nm, input cdrst_word_t seen, input cdrst_word_t exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input cdrst_addr_t a, input cdrst_word_t d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input cdrst_word_t opt, input cdrst_word_t epr, input cdrst_word_t tl);
        apb(1'b1, `CDRST_OFS_ENABLE, 32'h00000000);
        apb(1'b1, `CDRST_OFS_SELECT, `CDRST_SEL_CODE);
        // callers keep reserved option bits zero
        apb(1'b1, `CDRST_OFS_OPTION, opt);
        apb(1'b1, `CDRST_OFS_EPR, epr);
        apb(1'b1, `CDRST_OFS_TARGET, tl);
        apb(1'b1, `CDRST_OFS_ENABLE, 32'h00000001);
        n_clr = 0;
        n_flag = 0;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, cdrst_addr_t'(4 * i), 32'h00000000);
            chk("reset value", rdv, 32'h00000000);
            chk("read error", {31'h0, erv}, 32'h00000000);
        end
        apb(1'b0, 12'h01C, 32'h00000000);
        chk("unmapped error", {31'h0, erv}, 32'h00000001);
        apb(1'b1, `CDRST_OFS_COUNT, 32'h000000FF);
        chk("count write error", {31'h0, erv}, 32'h00000001);
        $display("test regs done");
    endtask

    task automatic t_repeat;
        int rises;
        cfg(32'h00000001, 32'h00000002, 32'h00000005);
        apb(1'b1, `CDRST_OFS_SELECT, 32'h0000000B);
        chk("active write error", {31'h0, erv}, 32'h00000001);
        apb(1'b0, `CDRST_OFS_SELECT, 32'h00000000);
        chk("selector kept", rdv, `CDRST_SEL_CODE);
        for (int i = 0; i < 8; i++) begin
            u_src.drive(i % 2 == 0, 1500);
            rises = (i + 2) / 2;
            apb(1'b0, `CDRST_OFS_COUNT, 32'h00000000);
            chk("repeat count", rdv, 32'(rises % 2));
            chk("repeat resets", 32'(n_clr), 32'(rises / 2));
            chk("flags every edge", 32'(n_flag), 32'(i + 1));
        end
        chk("target line", tgt_line, 32'h00000005);
        $display("test repeat done");
    endtask

    task automatic t_single;
        cfg(32'h00000004, 32'h00000001, 32'h00000007);
        for (int i = 0; i < 6; i++) begin
            u_src.drive(i % 2 == 0, 1500);
            apb(1'b0, `CDRST_OFS_COUNT, 32'h00000000);
            chk("falling count", rdv, 32'((i + 1) / 2));
            chk("single reset", 32'(n_clr), 32'(i > 0));
        end
        chk("target line", tgt_line, 32'h00000007);
        $display("test single done");
    endtask

    task automatic t_drop;
        cfg(32'h00000001, 32'h00000064, 32'h00000003);
        // both later edges land inside the first service
        u_src.drive(1'b1, 100);
        u_src.drive(1'b0, 100);
        u_src.drive(1'b1, 1500);
        apb(1'b0, `CDRST_OFS_COUNT, 32'h00000000);
        chk("count after drops", rdv, 32'h00000001);
        apb(1'b0, `CDRST_OFS_STATUS, 32'h00000000);
        chk("drop tally", 32'(rdv[15:8]), 32'h00000002);
        $display("test drop done");
    endtask

    task automatic t_lost;
        cfg(32'h00000001, 32'h00000064, 32'h00000003);
        other_isr_busy <= 1'b1;
        u_src.drive(1'b0, 100);
        u_src.drive(1'b1, 100);
        u_src.drive(1'b0, 100);
        chk("pending flag", 32'(line_irq_flag), 32'h00000001);
        chk("blocked service", 32'(line_isr_busy), 32'h00000000);
        other_isr_busy <= 1'b0;
        repeat (1500) @(posedge ref_clk);
        chk("flag cleared", 32'(line_irq_flag), 32'h00000000);
        apb(1'b0, `CDRST_OFS_COUNT, 32'h00000000);
        chk("rising edge lost", rdv, 32'h00000000);
        apb(1'b0, `CDRST_OFS_STATUS, 32'h00000000);
        chk("lost tally", 32'(rdv[23:16]), 32'h00000002);
        $display("test lost done");
    endtask

    task automatic t_stream;
        u_src.drive(1'b1, 700);
        stream_isr_busy <= 1'b1;
        repeat (1000) @(posedge ref_clk);
        stream_isr_busy <= 1'b0;
        chk("service frozen", 32'(line_isr_busy), 32'h00000001);
        repeat (800) @(posedge ref_clk);
        chk("service ended", 32'(line_isr_busy), 32'h00000000);
        apb(1'b0, `CDRST_OFS_COUNT, 32'h00000000);
        chk("count after stream", rdv, 32'h00000001);
        $display("test stream done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        $display("watchdog expired");
        stop_test;
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        other_isr_busy = 1'b0;
        stream_isr_busy = 1'b0;
        flag_d = 1'b0;
        n_fail = 0;
        check_count = 0;
        n_clr = 0;
        n_flag = 0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_regs;
        t_repeat;
        t_single;
        t_drop;
        t_lost;
        t_stream;
        stop_test;
    end
endmodule // test_cdrst_top
